// File: hw/fsr_cfg.svh
// Operation
// R1 - quality holds top eight of 10-bit feature count
// R2 - quality equals feature count divided by four
// R3 - quality never reported above 169
// R4 - no surface gives quality near zero
// R5 - 17-bit sum of 900 pixels, upper byte
// R6 - pixel sum 0 to 223, new each frame
// R7 - brightest pixel seven bits, each frame
// R8 - darkest pixel seven bits, each frame
// R9 - exposure 16-bit count in high/low bytes
// R10 - controller reads high byte, then low byte
// R11 - auto loop adjusts exposure every frame
// R12 - manual exposure via loop disable and ceiling
// R13 - exposure never exceeds programmed ceiling
// R14 - controller should also pick fixed frame rate
// R15 - reset values: 0x4e20 exposure, others zero
// R16 - loop disabled: exposure equals ceiling directly
// R17 - high byte read captures matching low byte
// R18 - all update per frame, writes ignored; exposure follows the ceiling between frames when the loop is disabled, else only clipped to it
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// register offsets on the serial port address space
`define FSR_ADDR_W          7
`define FSR_OFS_QUALITY     7'h07
`define FSR_OFS_INTENSITY   7'h08
`define FSR_OFS_BRIGHTEST   7'h09
`define FSR_OFS_DARKEST     7'h0a
`define FSR_OFS_EXP_LOW     7'h0b
`define FSR_OFS_EXP_HIGH    7'h0c

// reset values
`define FSR_RST_QUALITY     8'h00
`define FSR_RST_INTENSITY   8'h00
`define FSR_RST_BRIGHTEST   8'h00
`define FSR_RST_DARKEST     8'h00
`define FSR_RST_EXP_LOW     8'h20
`define FSR_RST_EXP_HIGH    8'h4e
`define FSR_RST_UNMAPPED    8'h00

// statistics layout
`define FSR_PIX_W           7
`define FSR_PIX_MAX         7'h7f
`define FSR_PIX_PER_FRAME   10'h384
`define FSR_SUM_W           17
`define FSR_SUM_LSB         9
`define FSR_FEAT_W          10
`define FSR_FEAT_SAT        10'h3ff
`define FSR_FEAT_LSB        2
`define FSR_QUAL_MAX        8'ha9

// exposure loop
`define FSR_EXP_W           16
`define FSR_EXP_TGT_LO      8'h60
`define FSR_EXP_TGT_HI      8'h90
`define FSR_EXP_STEP        16'h0100
`define FSR_EXP_MIN         16'h0010

`endif

// File: hw/fsr_frame_stats.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsr_cfg.svh"
module fsr_frame_stats (
	input  wire logic         clk_sys_i,
	input  wire logic         nrst_i,
	input  wire logic         frame_start_i,
	input  wire logic         frame_end_i,
	input  wire logic         pix_valid_i,
	input  wire fsr_pkg::fsr_pix_t pix_data_i,
	input  wire logic         feat_valid_i,
	input  wire logic         exp_loop_disable_i,
	input  wire fsr_pkg::fsr_exp_t exp_ceiling_i,
	input  wire fsr_pkg::fsr_addr_t reg_addr_i,
	input  wire logic         reg_rd_i,
	input  wire logic         reg_wr_i,
	input  wire fsr_pkg::fsr_byte_t reg_wdata_i,
	output fsr_pkg::fsr_byte_t reg_rdata_o,
	output logic              reg_rvalid_o,
	output fsr_pkg::fsr_exp_t exposure_o,
	output logic              stats_update_o
);
	import fsr_pkg::*;

	// lesser of two exposure values
	function automatic fsr_exp_t exp_min(input fsr_exp_t a, input fsr_exp_t b);
		exp_min = (a < b) ? a : b;
	endfunction : exp_min

	// one loop step up or down, saturating at both ends
	function automatic fsr_exp_t exp_step(input fsr_exp_t cur, input logic up);
		logic [`FSR_EXP_W:0] wide;
		wide = up ? ({1'b0, cur} + {1'b0, `FSR_EXP_STEP}) : ({1'b0, cur} - {1'b0, `FSR_EXP_STEP});
		if (up) begin
			exp_step = wide[`FSR_EXP_W] ? 16'hffff : wide[`FSR_EXP_W-1:0];
		end else begin
			exp_step = (wide[`FSR_EXP_W] || (wide[`FSR_EXP_W-1:0] < `FSR_EXP_MIN)) ?
			           `FSR_EXP_MIN : wide[`FSR_EXP_W-1:0];
		end
	endfunction : exp_step

	logic      acc_done;
	fsr_sum_t  acc_sum;
	fsr_pix_t  acc_max;
	fsr_pix_t  acc_min;
	fsr_feat_t acc_feat;

	fsr_byte_t quality_q;
	fsr_byte_t intensity_q;
	fsr_byte_t brightest_q;
	fsr_byte_t darkest_q;
	fsr_exp_t  exp_q;
	fsr_exp_t  exp_d;
	fsr_byte_t exp_low_hold_q;
	fsr_byte_t quality_d;
	fsr_byte_t avg_byte;

	// per-frame accumulation
	fsr_pixel_acc u_acc (
		.clk_sys_i     (clk_sys_i),
		.nrst_i        (nrst_i),
		.frame_start_i (frame_start_i),
		.frame_end_i   (frame_end_i),
		.pix_valid_i   (pix_valid_i),
		.pix_data_i    (pix_data_i),
		.feat_valid_i  (feat_valid_i),
		.done_o        (acc_done),
		.sum_o         (acc_sum),
		.max_o         (acc_max),
		.min_o         (acc_min),
		.feat_o        (acc_feat)
	);

	// quality is the feature count over four, capped
	always_comb begin
		quality_d = acc_feat[`FSR_FEAT_W-1:`FSR_FEAT_LSB]; // see R1 see R2 see R4
		if (quality_d > `FSR_QUAL_MAX) begin
			quality_d = `FSR_QUAL_MAX; // see R3
		end
	end

	assign avg_byte = acc_sum[`FSR_SUM_W-1:`FSR_SUM_LSB];

	// statistics registers load together once per frame, bus writes never touch them
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			quality_q   <= `FSR_RST_QUALITY; // see R15
			intensity_q <= `FSR_RST_INTENSITY;
			brightest_q <= `FSR_RST_BRIGHTEST;
			darkest_q   <= `FSR_RST_DARKEST;
		end else if (acc_done) begin
			quality_q   <= quality_d; // see R18
			intensity_q <= avg_byte; // see R5 see R6
			brightest_q <= {1'b0, acc_max}; // see R7
			darkest_q   <= {1'b0, acc_min}; // see R8
		end
	end

	// exposure: manual follows the ceiling, auto steps toward the target window
	always_comb begin
		exp_d = exp_q;
		if (exp_loop_disable_i) begin
			exp_d = exp_ceiling_i; // see R12 see R16
		end else if (acc_done) begin
			if (avg_byte < `FSR_EXP_TGT_LO) begin
				exp_d = exp_step(exp_q, 1'b1); // see R11
			end else if (avg_byte > `FSR_EXP_TGT_HI) begin
				exp_d = exp_step(exp_q, 1'b0); // see R11
			end
		end
		exp_d = exp_min(exp_d, exp_ceiling_i); // see R13
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			exp_q <= {`FSR_RST_EXP_HIGH, `FSR_RST_EXP_LOW}; // see R9 see R15
		end else begin
			exp_q <= exp_d;
		end
	end

	// a high byte read freezes the low byte for the read that follows
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			exp_low_hold_q <= `FSR_RST_EXP_LOW;
		end else if (reg_rd_i && (reg_addr_i == `FSR_OFS_EXP_HIGH)) begin
			exp_low_hold_q <= exp_q[7:0]; // see R17 see R10
		end
	end

	// registered read answer, unmapped offsets read zero
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			reg_rdata_o  <= `FSR_RST_UNMAPPED;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`FSR_OFS_QUALITY:   reg_rdata_o <= quality_q;
					`FSR_OFS_INTENSITY: reg_rdata_o <= intensity_q;
					`FSR_OFS_BRIGHTEST: reg_rdata_o <= brightest_q;
					`FSR_OFS_DARKEST:   reg_rdata_o <= darkest_q;
					`FSR_OFS_EXP_LOW:   reg_rdata_o <= exp_low_hold_q; // see R17
					`FSR_OFS_EXP_HIGH:  reg_rdata_o <= exp_q[15:8]; // see R9
					default:            reg_rdata_o <= `FSR_RST_UNMAPPED;
				endcase
			end
		end
	end

	assign exposure_o     = exp_q;
	assign stats_update_o = acc_done;

	// checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	logic [`FSR_EXP_W:0] exp_room;
	assign exp_room = {1'b0, exp_ceiling_i} - {1'b0, `FSR_EXP_STEP};

	AST_QUAL_CAP: assert property (quality_q <= `FSR_QUAL_MAX) // see R3
		else $error("quality above cap");

	AST_QUAL_DIV4: assert property (acc_done |=> // see R2
		quality_q == (($past(acc_feat) >> 2) > 10'h0a9 ? `FSR_QUAL_MAX : 8'($past(acc_feat) >> 2)))
		else $error("quality not feature count over four");

	AST_SUM_UPPER: assert property (acc_done |=> intensity_q == $past(acc_sum[16:9])) // see R5
		else $error("pixel sum byte wrong");

	AST_SUM_RANGE: assert property (intensity_q <= 8'hdf) // see R6
		else $error("pixel sum above range");

	AST_PIX_7BIT: assert property (!brightest_q[7] && !darkest_q[7]) // see R7
		else $error("pixel level uses bit seven");

	AST_MIN_LE_MAX: assert property (acc_done && (acc_sum != '0) |=> // see R8
		darkest_q <= brightest_q)
		else $error("darkest above brightest");

	AST_EXP_CEIL: assert property ($past(nrst_i) |-> exp_q <= $past(exp_ceiling_i)) // see R13
		else $error("exposure above ceiling");

	AST_MANUAL: assert property (exp_loop_disable_i |=> exp_q == $past(exp_ceiling_i)) // see R16
		else $error("manual exposure not at ceiling");

	AST_AUTO_UP: assert property ((acc_done && !exp_loop_disable_i && avg_byte < `FSR_EXP_TGT_LO && // see R11
		!exp_room[16] && {1'b0, exp_q} <= exp_room) ##1 $stable(exp_ceiling_i) |->
		exp_q == $past(exp_q) + `FSR_EXP_STEP)
		else $error("auto loop did not raise exposure");

	AST_HOLD_LOW: assert property (reg_rd_i && reg_addr_i == `FSR_OFS_EXP_HIGH ##1 // see R17
		reg_rd_i && reg_addr_i == `FSR_OFS_EXP_LOW |=> reg_rdata_o == $past(exp_q[7:0], 2))
		else $error("low byte not coherent with high");

	AST_WR_IGNORED: assert property (reg_wr_i && !acc_done |=> $stable(quality_q) && $stable(intensity_q)) // see R18
		else $error("write changed a statistic");

	AST_RESET_EXP: assert property ($rose(nrst_i) |-> exp_q == 16'h4e20 && quality_q == 8'h00) // see R15
		else $error("reset values wrong");

	// statistics only move on a frame completion
	AST_STATS_HOLD: assert property (!acc_done |=> $stable(quality_q) && $stable(intensity_q) && // see R18
		$stable(brightest_q) && $stable(darkest_q))
		else $error("statistic changed outside frame completion");

	// auto loop leaves exposure alone between frames while under the ceiling
	AST_AUTO_HOLD: assert property (!exp_loop_disable_i && !acc_done && exp_q <= exp_ceiling_i |=> // see R11
		$stable(exp_q))
		else $error("exposure moved between frames");

	// read answers carry the register seen at the strobe
	AST_EXP_HIGH_READ: assert property (reg_rd_i && reg_addr_i == `FSR_OFS_EXP_HIGH |=> // see R9
		reg_rdata_o == $past(exp_q[15:8]))
		else $error("exposure high byte read wrong");

	AST_QUAL_READ: assert property (reg_rd_i && reg_addr_i == `FSR_OFS_QUALITY |=> // see R1
		reg_rdata_o == $past(quality_q))
		else $error("quality read wrong");

	COV_AUTO_DOWN: cover property (acc_done && !exp_loop_disable_i && avg_byte > `FSR_EXP_TGT_HI);
	COV_FRAME: cover property (acc_done ##1 intensity_q != 8'h00);
	COV_MANUAL: cover property (exp_loop_disable_i ##1 exp_q == exp_ceiling_i);
	COV_PAIR_READ: cover property (reg_rd_i && reg_addr_i == `FSR_OFS_EXP_HIGH ##1
		reg_rd_i && reg_addr_i == `FSR_OFS_EXP_LOW);
endmodule : fsr_frame_stats
`default_nettype wire

// File: hw/fsr_pixel_acc.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsr_cfg.svh"
module fsr_pixel_acc (
	input  wire logic          clk_sys_i,
	input  wire logic          nrst_i,
	input  wire logic          frame_start_i,
	input  wire logic          frame_end_i,
	input  wire logic          pix_valid_i,
	input  wire fsr_pkg::fsr_pix_t pix_data_i,
	input  wire logic          feat_valid_i,
	output logic               done_o,
	output fsr_pkg::fsr_sum_t  sum_o,
	output fsr_pkg::fsr_pix_t  max_o,
	output fsr_pkg::fsr_pix_t  min_o,
	output fsr_pkg::fsr_feat_t feat_o
);
	import fsr_pkg::*;

	fsr_acq_t  state_q;
	fsr_feat_t pix_cnt_q;
	logic      take_pix;

	// only the first 900 pixels of a running frame count
	assign take_pix = (state_q == FSR_ACQ_RUN) && pix_valid_i && (pix_cnt_q < `FSR_PIX_PER_FRAME);

	// frame sequencing
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			state_q <= FSR_ACQ_IDLE;
		end else begin
			case (state_q)
				FSR_ACQ_IDLE: begin
					if (frame_start_i) begin
						state_q <= FSR_ACQ_RUN;
					end
				end
				FSR_ACQ_RUN: begin
					if (frame_end_i && !frame_start_i) begin
						state_q <= FSR_ACQ_IDLE;
					end
				end
				default: state_q <= FSR_ACQ_IDLE;
			endcase
		end
	end

	// completion pulse one cycle after the frame end
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= (state_q == FSR_ACQ_RUN) && frame_end_i;
		end
	end

	// pixel sum, extremes and pixel count
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || frame_start_i) begin
			pix_cnt_q <= '0;
			sum_o     <= '0;
			max_o     <= '0;
			min_o     <= `FSR_PIX_MAX;
		end else if (take_pix) begin
			pix_cnt_q <= pix_cnt_q + 10'h001;
			sum_o     <= sum_o + {10'h000, pix_data_i}; // see R5
			if (pix_data_i > max_o) begin
				max_o <= pix_data_i; // see R7
			end
			if (pix_data_i < min_o) begin
				min_o <= pix_data_i; // see R8
			end
		end
	end

	// valid feature count, saturating at ten bits
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || frame_start_i) begin
			feat_o <= '0;
		end else if ((state_q == FSR_ACQ_RUN) && feat_valid_i && (feat_o != `FSR_FEAT_SAT)) begin
			feat_o <= feat_o + 10'h001; // see R1
		end
	end
endmodule : fsr_pixel_acc
`default_nettype wire

// File: hw/fsr_pkg.sv
`include "fsr_cfg.svh"
package fsr_pkg;
	typedef logic [7:0]                 fsr_byte_t;
	typedef logic [`FSR_PIX_W-1:0]      fsr_pix_t;
	typedef logic [`FSR_SUM_W-1:0]      fsr_sum_t;
	typedef logic [`FSR_FEAT_W-1:0]     fsr_feat_t;
	typedef logic [`FSR_EXP_W-1:0]      fsr_exp_t;
	typedef logic [`FSR_ADDR_W-1:0]     fsr_addr_t;
	typedef enum logic {FSR_ACQ_IDLE, FSR_ACQ_RUN} fsr_acq_t;
endpackage : fsr_pkg

// File: tb/fsr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsr_cfg.svh"
module fsr_host_model (
	input  wire logic          clk_sys_i,
	input  wire fsr_pkg::fsr_byte_t rdata_i,
	input  wire logic          rvalid_i,
	output fsr_pkg::fsr_addr_t addr_o,
	output logic               rd_o,
	output logic               wr_o,
	output fsr_pkg::fsr_byte_t wdata_o
);
	import fsr_pkg::*;
	// idle port: no strobes
	initial begin
		addr_o = '0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = '0;
	end
	// one access: strobe held one cycle, answer taken once settled
	task acc(input fsr_addr_t a, input logic w, input fsr_byte_t d, output fsr_byte_t q, output logic v);
		@(posedge clk_sys_i);
		#1;
		addr_o = a;
		rd_o = !w;
		wr_o = w;
		wdata_o = d;
		@(posedge clk_sys_i);
		#1;
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = ~a; // released lines do not keep the old value
		wdata_o = ~d;
		q = rdata_i;
		v = rvalid_i;
	endtask : acc
	// exposure pair: high byte read, then low byte read on the very next cycle, nothing between
	task rd_pair(output fsr_byte_t hi, output fsr_byte_t lo);
		@(posedge clk_sys_i);
		#1;
		addr_o = `FSR_OFS_EXP_HIGH;
		rd_o = 1'b1;
		wr_o = 1'b0;
		@(posedge clk_sys_i);
		#1;
		hi = rdata_i;
		addr_o = `FSR_OFS_EXP_LOW;
		@(posedge clk_sys_i);
		#1;
		lo = rdata_i;
		rd_o = 1'b0;
		addr_o = ~`FSR_OFS_EXP_LOW;
	endtask : rd_pair
endmodule : fsr_host_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import fsr_pkg::*;
	logic      clk_sys_i, nrst_i, fstart, fend, pvalid, fvalid, dis, rd, wr, rvalid, upd;
	fsr_pix_t  pix;
	fsr_exp_t  ceil, expo;
	fsr_addr_t addr;
	fsr_byte_t wdata, rdata, q, hq;
	logic      v;
	int        num_errors = 0;
	int        checks_done = 0;
	// 25 MHz clock
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	fsr_frame_stats fsr_frame_stats_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .frame_start_i(fstart),
		.frame_end_i(fend), .pix_valid_i(pvalid), .pix_data_i(pix), .feat_valid_i(fvalid),
		.exp_loop_disable_i(dis), .exp_ceiling_i(ceil), .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .exposure_o(expo),
		.stats_update_o(upd));
	fsr_host_model fsr_host_model_i (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid),
		.addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : chk
	task results;
		if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	task rdchk(input fsr_addr_t a, input fsr_byte_t e);
		fsr_host_model_i.acc(a, 1'b0, 8'h00, q, v);
		chk("rvalid", {15'h0, v}, 16'h1);
		chk("rdata", {8'h0, q}, {8'h0, e});
	endtask : rdchk
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	// one frame: n pixels of level v (pixel 3 reads 5), first nf carry a feature
	task frame(input int n, input fsr_pix_t v, input int nf);
		int k;
		cyc(1);
		fstart = 1'b1;
		cyc(1);
		fstart = 1'b0;
		for (int i = 0; i < n; i++) begin
			pvalid = 1'b1;
			pix = (i == 3) ? 7'h05 : v;
			fvalid = (i < nf);
			fend = (i == n - 1);
			cyc(1);
		end
		pvalid = 1'b0;
		fvalid = 1'b0;
		fend = 1'b0;
		k = 0;
		while (upd !== 1'b1 && k < 8) begin
			cyc(1);
			k++;
		end
		chk("update", {15'h0, upd}, 16'h1);
		if (k == 8) results();
		cyc(2);
	endtask : frame
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		num_errors++;
		results();
	end
	initial begin
		{nrst_i, fstart, fend, pvalid, fvalid, dis} = '0;
		pix = '0;
		ceil = 16'hffff;
		cyc(20);
		nrst_i = 1'b1;
		cyc(2);
		chk("exposure", expo, 16'h4e20);
		for (int a = 7; a < 13; a++) rdchk(a[6:0], a == 11 ? 8'h20 : a == 12 ? 8'h4e : 8'h00);
		rdchk(7'h0d, 8'h00);
		fsr_host_model_i.acc(7'h07, 1'b1, 8'hff, q, v);
		rdchk(7'h07, 8'h00);
		frame(903, 7'h7f, 700);
		rdchk(7'h07, 8'ha9);
		rdchk(7'h08, 8'hdf);
		rdchk(7'h09, 8'h7f);
		rdchk(7'h0a, 8'h05);
		chk("exposure", expo, 16'h4d20);
		rdchk(7'h0c, 8'h4d);
		rdchk(7'h0b, 8'h20);
		frame(900, 7'h00, 13);
		rdchk(7'h07, 8'h03);
		rdchk(7'h08, 8'h00);
		rdchk(7'h09, 8'h05);
		rdchk(7'h0a, 8'h00);
		chk("exposure", expo, 16'h4e20);
		dis = 1'b1;
		ceil = 16'h1234;
		cyc(3);
		chk("exposure", expo, 16'h1234);
		frame(900, 7'h00, 0);
		chk("exposure", expo, 16'h1234);
		rdchk(7'h0c, 8'h12);
		ceil = 16'h5678;
		cyc(3);
		rdchk(7'h0b, 8'h34);
		chk("exposure", expo, 16'h5678);
		dis = 1'b0;
		ceil = 16'h1000;
		cyc(3);
		chk("exposure", expo, 16'h1000);
		fsr_host_model_i.rd_pair(hq, q);
		chk("pair high", {8'h0, hq}, 16'h0010);
		chk("pair low", {8'h0, q}, 16'h0000);
		results();
	end
endmodule : testbench
`default_nettype wire
